/* inc/wss_pkg.sv */
/*
 wake/sleep supervisor package: constants, timing and mode encodings.
 assumes a single 100 MHz reference clock.
*/
// Behaviour
// - after both supplies first appear the device enters sleep and watches its ports for a wake-up.
// - in sleep a wake-up seen on the iso UART or the UART port starts the start-up procedure.
// - in normal mode ongoing traffic on either port refreshes the watchdog, and the host must talk often enough.
// - the watchdog period is set by software through the communication-timeout count.
// - when the watchdog expires the device falls back to sleep by itself.
// - in normal mode, setting the power-down request sends the device straight to sleep; start-up ignores it.
// - when an important internal supply drops below its valid level the device enters sleep.
// - sleep entered through a supply fault sets the supply-fault-sleep flag.
// - the cell partition selects a contiguous group of active cells starting at cell 11.
// - the round robin measures and checks only enabled cells and skips disabled ones.
// - a supply fault is deglitched, typically 15 us, between 8 us and 24 us.
package wss_pkg;
	localparam int CLK_PERIOD_NS    = 10;
	localparam int FAULT_DEG_TYP_NS = 15000;
	localparam int FAULT_DEG_CYC    = (FAULT_DEG_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WDOG_TICK_NS     = 1000;
	localparam int WDOG_TICK_CYC    = WDOG_TICK_NS / CLK_PERIOD_NS;
	localparam int NUM_CELLS        = 12;
	localparam int TOP_CELL         = 11;
	localparam int CELL_IDX_W       = 4;
	localparam int WDOG_W           = 16;
	localparam int PART_W           = 4;
	localparam int STARTUP_CYC      = 16;
	localparam logic [WDOG_W-1:0] WDOG_RESET = 16'h00FF;

	typedef enum logic [1:0] {
		WSS_SLEEP   = 2'b00,
		WSS_STARTUP = 2'b01,
		WSS_NORMAL  = 2'b10
	} wss_mode_t;
endpackage

/* logic/wss_deglitch.sv */
/*
 supply fault deglitch filter: the output follows the input only after it
 has held steady for the filter time.
 assumes the fault input has already been synchronised.
*/
`timescale 1ns/1ps
module wss_deglitch
	import wss_pkg::*;
#(
	parameter int FILT_CYC = FAULT_DEG_CYC
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic clk_en,
	// filter
	input  wire logic raw_in,
	output logic      filt_out
);
	localparam int CW = $clog2(FILT_CYC + 1);
	logic [CW-1:0] cnt;
	wire           differs = raw_in != filt_out;
	wire           done    = cnt == CW'(FILT_CYC - 1);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt      <= '0;
			filt_out <= 1'b0;
		end else if (clk_en) begin
			if (!differs)
				cnt <= '0;
			else if (done) begin
				cnt      <= '0;
				filt_out <= raw_in;
			end else
				cnt <= cnt + CW'(1);
		end
	end
endmodule // wss_deglitch

/* logic/wss_cell_rr.sv */
/*
 round-robin cell scanner: steps through the cells enabled by the partition
 setting, from the top cell down, and wraps.
 assumes a measurement strobe from the measurement logic.
*/
`timescale 1ns/1ps
module wss_cell_rr
	import wss_pkg::*;
(
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rst_b,
	input  wire logic                  clk_en,
	// control
	input  wire logic                  run,
	input  wire logic                  step,
	input  wire logic [PART_W-1:0]     part_cells,
	// status
	output logic      [NUM_CELLS-1:0]  cell_enable,
	output logic      [CELL_IDX_W-1:0] cell_idx
);
	wire [CELL_IDX_W-1:0] lowest;
	wire [CELL_IDX_W-1:0] count_m1;
	wire [NUM_CELLS-1:0]  next_enable;

	// zero means all cells
	assign count_m1 = (part_cells == '0 || part_cells > PART_W'(NUM_CELLS - 1)) ?
		CELL_IDX_W'(NUM_CELLS - 1) : CELL_IDX_W'(part_cells - PART_W'(1));
	assign lowest = CELL_IDX_W'(TOP_CELL) - count_m1;

	genvar g;
	generate
		for (g = 0; g < NUM_CELLS; g++) begin : g_en
			assign next_enable[g] = CELL_IDX_W'(g) >= lowest;
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cell_enable <= '0;
			cell_idx    <= CELL_IDX_W'(TOP_CELL);
		end else if (clk_en) begin
			cell_enable <= next_enable;
			if (!run)
				cell_idx <= CELL_IDX_W'(TOP_CELL);
			else if (step)
				cell_idx <= (cell_idx <= lowest) ? CELL_IDX_W'(TOP_CELL) :
					cell_idx - CELL_IDX_W'(1);
		end
	end
endmodule // wss_cell_rr

/* logic/wss_supervisor.sv */
/*
 wake/sleep supervisor: sleep, start-up and normal modes, communication
 watchdog, power-down request, deglitched supply fault with sticky flag,
 and the cell partition for the round robin.
 assumes wake and frame strobes come from the port receivers as pins,
 supply-good levels from the analog monitors; all are synchronised here.
*/
`timescale 1ns/1ps
module wss_supervisor
	import wss_pkg::*;
#(
	parameter int FILT_CYC = FAULT_DEG_CYC,
	parameter int TICK_CYC = WDOG_TICK_CYC
) (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rst_b,
	input  wire logic                  clk_en,
	// supplies
	input  wire logic                  main_supply_ok,
	input  wire logic                  block_sense_supply_ok,
	input  wire logic                  internal_supply_fault,
	// communication ports
	input  wire logic                  iso_wake,
	input  wire logic                  uart_wake,
	input  wire logic                  iso_frame_ok,
	input  wire logic                  uart_frame_ok,
	// configuration
	input  wire logic [WDOG_W-1:0]     comm_timeout_count,
	input  wire logic                  power_down_request,
	input  wire logic [PART_W-1:0]     part_cells,
	input  wire logic                  fault_flag_clear,
	input  wire logic                  meas_step,
	// status
	output wss_mode_t                  mode,
	output logic                       normal_mode,
	output logic                       supply_fault_sleep_flag,
	output logic      [WDOG_W-1:0]     wdog_remaining,
	output logic      [NUM_CELLS-1:0]  cell_enable,
	output logic      [CELL_IDX_W-1:0] cell_idx
);
	localparam int TW = $clog2(TICK_CYC + 1);
	localparam int SW = $clog2(STARTUP_CYC + 1);
	localparam int NS = 7;

	// two-flop synchronisers for every pin input
	logic [NS-1:0] s1;
	logic [NS-1:0] s2;
	wire  [NS-1:0] pins = {main_supply_ok, block_sense_supply_ok, internal_supply_fault,
		iso_wake, uart_wake, iso_frame_ok, uart_frame_ok};

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1 <= '0;
			s2 <= '0;
		end else if (clk_en) begin
			s1 <= pins;
			s2 <= s1;
		end
	end

	wire main_ok   = s2[6];
	wire sense_ok  = s2[5];
	wire fault_raw = s2[4];
	wire iso_w     = s2[3];
	wire uart_w    = s2[2];
	wire iso_f     = s2[1];
	wire uart_f    = s2[0];

	// edge detect on frame levels
	logic iso_f_d;
	logic uart_f_d;
	wire  frame_seen = (iso_f & ~iso_f_d) | (uart_f & ~uart_f_d);
	wire  wake_seen  = iso_w | uart_w;

	wire fault_filt;
	wss_deglitch #(.FILT_CYC(FILT_CYC)) u_deg (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.raw_in   (fault_raw),
		.filt_out (fault_filt)
	);

	wire supplies_up = main_ok & sense_ok;

	// watchdog tick and countdown
	logic [TW-1:0] tick_cnt;
	logic [SW-1:0] start_cnt;
	wire           tick      = tick_cnt == TW'(TICK_CYC - 1);
	wire           wdog_zero = wdog_remaining == '0;
	wire           in_normal = mode == WSS_NORMAL;
	wire           wdog_exp  = in_normal & wdog_zero & ~frame_seen;
	wire           fault_go  = (mode != WSS_SLEEP) & fault_filt;
	wire           start_end = start_cnt == SW'(STARTUP_CYC - 1);

	wss_mode_t next_mode;

	always_comb begin
		next_mode = mode;
		case (mode)
			WSS_SLEEP: begin
				if (supplies_up && !fault_filt && wake_seen)
					next_mode = WSS_STARTUP;
			end
			WSS_STARTUP: begin
				if (fault_filt || !supplies_up)
					next_mode = WSS_SLEEP;
				else if (start_end)
					next_mode = WSS_NORMAL;
			end
			WSS_NORMAL: begin
				if (fault_filt || !supplies_up)
					next_mode = WSS_SLEEP;
				else if (power_down_request)
					next_mode = WSS_SLEEP;
				else if (wdog_exp)
					next_mode = WSS_SLEEP;
			end
			default: next_mode = WSS_SLEEP;
		endcase
	end

	// reset lands in sleep, waiting for a wake-up
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			mode <= WSS_SLEEP;
		else if (clk_en)
			mode <= next_mode;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			iso_f_d  <= 1'b0;
			uart_f_d <= 1'b0;
		end else if (clk_en) begin
			iso_f_d  <= iso_f;
			uart_f_d <= uart_f;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			start_cnt <= '0;
		else if (clk_en)
			start_cnt <= (mode == WSS_STARTUP) ? start_cnt + SW'(1) : '0;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			tick_cnt <= '0;
		else if (clk_en)
			tick_cnt <= (!in_normal || tick) ? '0 : tick_cnt + TW'(1);
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			wdog_remaining <= WDOG_RESET;
		else if (clk_en) begin
			if (!in_normal || frame_seen)
				wdog_remaining <= comm_timeout_count;
			else if (tick && !wdog_zero)
				wdog_remaining <= wdog_remaining - WDOG_W'(1);
		end
	end

	// sticky fault flag; a new fault wins over a clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			supply_fault_sleep_flag <= 1'b0;
		else if (clk_en) begin
			if (fault_go)
				supply_fault_sleep_flag <= 1'b1;
			else if (fault_flag_clear)
				supply_fault_sleep_flag <= 1'b0;
		end
	end

	assign normal_mode = in_normal;

	wss_cell_rr u_rr (
		.ref_clk     (ref_clk),
		.rst_b       (rst_b),
		.clk_en      (clk_en),
		.run         (in_normal),
		.step        (meas_step),
		.part_cells  (part_cells),
		.cell_enable (cell_enable),
		.cell_idx    (cell_idx)
	);
endmodule // wss_supervisor

/* bench/wss_checker.sv */
/*
 supervisor checker: mode order, watchdog, power-down, fault flag, cells.
 assumes clk_en is held high.
*/
`timescale 1ns/1ps
module wss_checker
	import wss_pkg::*;
(
	// clock and reset
	input wire logic                 ref_clk,
	input wire logic                 rst_b,
	// watched ports
	input wire logic [WDOG_W-1:0]    comm_timeout_count,
	input wire logic                 power_down_request,
	input wire logic                 fault_flag_clear,
	input wss_mode_t                 mode,
	input wire logic                 supply_fault_sleep_flag,
	input wire logic [WDOG_W-1:0]    wdog_remaining,
	input wire logic [NUM_CELLS-1:0] cell_enable
);
	logic [4:0]  st_cnt;
	wire  [11:0] ce_inv = ~cell_enable;
	// counts cycles spent in start-up
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			st_cnt <= 5'h0;
		else
			st_cnt <= (mode == WSS_STARTUP) ? st_cnt + 5'h1 : 5'h0;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	mode_order_a: assert property (mode == WSS_SLEEP |=> mode != WSS_NORMAL)
		else $error("normal straight from sleep");
	startup_len_a: assert property (mode == WSS_NORMAL && st_cnt != 0 |-> st_cnt == 5'h10)
		else $error("start-up length wrong");
	wdog_load_a: assert property ($rose(mode == WSS_NORMAL) |-> wdog_remaining == comm_timeout_count)
		else $error("watchdog not loaded");
	wdog_expire_a: assert property (mode == WSS_NORMAL && wdog_remaining == 16'h0000 |=>
		mode == WSS_SLEEP || wdog_remaining == comm_timeout_count)
		else $error("no sleep on timeout");
	pd_sleep_a: assert property (mode == WSS_NORMAL && power_down_request |=> mode == WSS_SLEEP)
		else $error("power-down ignored");
	flag_cause_a: assert property ($rose(supply_fault_sleep_flag) |-> mode == WSS_SLEEP && $past(mode) != WSS_SLEEP)
		else $error("flag set without sleep entry");
	flag_hold_a: assert property (supply_fault_sleep_flag && !fault_flag_clear |=> supply_fault_sleep_flag)
		else $error("flag lost");
	cell_group_a: assert property ((ce_inv & (ce_inv + 12'h001)) == 12'h000)
		else $error("cell group not from top");
endmodule // wss_checker

bind wss_supervisor wss_checker u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
	.comm_timeout_count(comm_timeout_count), .power_down_request(power_down_request),
	.fault_flag_clear(fault_flag_clear), .mode(mode), .cell_enable(cell_enable),
	.supply_fault_sleep_flag(supply_fault_sleep_flag), .wdog_remaining(wdog_remaining));

/* bench/wss_host_model.sv */
/*
 host model: raises a wake-up level or a frame strobe on the chosen port.
 assumes one request pulse from the bench per transfer.
*/
`timescale 1ns/1ps
module wss_host_model (
	// control
	input  wire logic ref_clk,
	input  wire logic wake_go,
	input  wire logic frame_go,
	input  wire logic use_iso,
	// port pins
	output logic      iso_wake,
	output logic      uart_wake,
	output logic      iso_frame_ok,
	output logic      uart_frame_ok
);
	logic [3:0] wk = 4'h0;
	logic [1:0] fr = 2'h0;
	logic       sel = 1'b0;
	// wake lasts four cycles so it outlasts the synchroniser
	always @(posedge ref_clk) begin
		wk <= {wk[2:0], wake_go};
		fr <= {fr[0], frame_go};
		if (wake_go || frame_go)
			sel <= use_iso;
	end
	assign iso_wake = sel & (|wk);
	assign uart_wake = !sel & (|wk);
	assign iso_frame_ok = sel & (|fr);
	assign uart_frame_ok = !sel & (|fr);
endmodule // wss_host_model

/* bench/wss_supervisor_bench.sv */
/*
 bench: wake, watchdog, power-down, fault and cell tests.
 assumes the host model drives the port pins.
*/
`timescale 1ns/1ps
module wss_supervisor_bench
	import wss_pkg::*;
;
	logic ref_clk = 0, rst_b = 0, fault = 0, pd = 0, clr = 0, mstep = 0;
	logic msup = 0, ssup = 1, nm;
	logic wake_go = 0, frame_go = 0, use_iso = 0, flag, isw, uw, isf, uf;
	logic [15:0] count = 16'h0008, wdog;
	logic [11:0] cen;
	logic [3:0] part = 4'h0, cidx;
	wss_mode_t mode;
	int fails = 0, n_checks = 0, cyc = 0;
	wss_supervisor #(.FILT_CYC(4), .TICK_CYC(2)) u_wss_supervisor (.ref_clk(ref_clk),
		.rst_b(rst_b), .clk_en(1'b1), .main_supply_ok(msup), .block_sense_supply_ok(ssup),
		.internal_supply_fault(fault), .iso_wake(isw), .uart_wake(uw), .iso_frame_ok(isf),
		.uart_frame_ok(uf), .comm_timeout_count(count), .power_down_request(pd),
		.part_cells(part), .fault_flag_clear(clr), .meas_step(mstep), .mode(mode),
		.normal_mode(nm), .supply_fault_sleep_flag(flag), .wdog_remaining(wdog),
		.cell_enable(cen), .cell_idx(cidx));
	wss_host_model u_wss_host_model (.ref_clk(ref_clk), .wake_go(wake_go),
		.frame_go(frame_go), .use_iso(use_iso), .iso_wake(isw), .uart_wake(uw),
		.iso_frame_ok(isf), .uart_frame_ok(uf));
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			final_report();
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_m(input wss_mode_t exp);
		chk_v({14'h0000, mode}, {14'h0000, exp});
		chk_v({15'h0000, nm}, {15'h0000, (exp == WSS_NORMAL) ? 1'b1 : 1'b0});
	endtask
	task automatic wait_m(input wss_mode_t m, input int lim);
		for (int i = 0; i < lim && mode !== m; i++)
			step(1);
		chk_m(m);
	endtask
	task automatic pulse_wake(input logic iso);
		use_iso <= iso;
		wake_go <= 1'b1;
		step(1);
		wake_go <= 1'b0;
	endtask
	task automatic wake(input logic iso);
		pulse_wake(iso);
		wait_m(WSS_STARTUP, 10);
		wait_m(WSS_NORMAL, 20);
	endtask
	task automatic final_report();
		if (fails == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		logic [11:0] e;
		step(10);
		chk_v(wdog, WDOG_RESET);
		rst_b <= 1'b1;
		step(2);
		chk_v(wdog, 16'h0008);
		pulse_wake(1'b0);
		step(10);
		chk_m(WSS_SLEEP);
		msup <= 1'b1;
		pd <= 1'b1;
		step(30);
		chk_m(WSS_SLEEP);
		pd <= 1'b0;
		wake(1'b0);
		chk_v(wdog, 16'h0008);
		repeat (6) begin
			use_iso <= ~use_iso;
			frame_go <= 1'b1;
			step(1);
			frame_go <= 1'b0;
			step(9);
		end
		chk_m(WSS_NORMAL);
		wait_m(WSS_SLEEP, 40);
		count <= 16'h0003;
		wake(1'b1);
		chk_v(wdog, 16'h0003);
		wait_m(WSS_SLEEP, 12);
		count <= 16'hFFFF;
		wake(1'b1);
		pd <= 1'b1;
		step(2);
		chk_m(WSS_SLEEP);
		pd <= 1'b0;
		wake(1'b0);
		for (int p = 0; p < 14; p++) begin
			part <= p[3:0];
			step(3);
			e = (p == 0 || p > 12) ? 12'hFFF : 12'hFFF << (12 - p);
			chk_v({4'h0, cen}, {4'h0, e});
			mstep <= 1'b1;
			step(3);
			mstep <= 1'b0;
			chk_v({15'h0000, cen[cidx]}, 16'h0001);
		end
		fault <= 1'b1;
		step(2);
		fault <= 1'b0;
		step(12);
		chk_m(WSS_NORMAL);
		fault <= 1'b1;
		step(4);
		chk_m(WSS_NORMAL);
		wait_m(WSS_SLEEP, 15);
		fault <= 1'b0;
		step(10);
		chk_v({15'h0000, flag}, 16'h0001);
		clr <= 1'b1;
		step(1);
		clr <= 1'b0;
		step(2);
		chk_v({15'h0000, flag}, 16'h0000);
		wake(1'b1);
		ssup <= 1'b0;
		step(5);
		chk_m(WSS_SLEEP);
		chk_v({15'h0000, flag}, 16'h0000);
		final_report();
	end
endmodule // wss_supervisor_bench
